/* logic/telemetry_map.vh */
`ifndef TELEMETRY_MAP_VH
`define TELEMETRY_MAP_VH

// Command codes
`define CMD_VIN 8'h88
`define CMD_VIN_PEAK 8'hDE
`define CMD_VOUT 8'h8B
`define CMD_VOUT_PEAK 8'hDD
`define CMD_IOUT 8'h8C
`define CMD_IOUT_PEAK 8'hD7
`define CMD_POUT 8'h96
`define CMD_EXT_TEMP 8'h8D
`define CMD_EXT_TEMP_PEAK 8'hDF
`define CMD_INT_TEMP 8'h8E
`define CMD_DUTY 8'h94
`define CMD_FREQ 8'h95
`define CMD_CLEAR_PEAKS 8'hE3

// Transaction kinds from the protocol engine
`define KIND_READ_WORD 2'h0
`define KIND_SEND_BYTE 2'h1
`define KIND_WRITE 2'h2

// Fixed-point layout of measurements
`define MEAS_W 24
`define Q_FRAC 8
`define VOUT_FRAC 12
`define IGAIN_FRAC 8
`define TGAIN_FRAC 14
`define TC_SHIFT1 14
`define TC_SHIFT2 14
`define REF_TEMP_Q8 24'sh001B00

// Linear 11-bit encoding
`define L11_BASE_EXP 6'h38
`define L11_MANT_MAX 48'sh0000000003FF
`define L11_MANT_MIN 48'shFFFFFFFFFC00
`define L11_MAX_SHIFT 23
`define L11_FIX_SHIFT 16

// Peak slots
`define PEAK_N 7
`define PK_VIN 0
`define PK_VOUT0 1
`define PK_IOUT0 3
`define PK_TEMP0 5

`define WORD_ZERO 16'h0000

`endif

/* logic/peak_hold.v */
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_map.vh"

module peak_hold #(
  parameter UNSIGNED_FMT = 0
) (
  input wire clk,
  input wire sys_rst,
  input wire clear,
  input wire sample_stb,
  input wire [15:0] sample_word,
  output reg [15:0] peak_word
);

  reg have_reg;

  // Linear 11-bit word to a comparable signed fixed value
  function signed [63:0] l11_fixed;
    input [15:0] w;
    reg signed [63:0] m;
    reg signed [5:0] e;
    begin
      m = {{53{w[10]}}, w[10:0]};
      e = {w[15], w[15:11]} + 6'sd16;
      l11_fixed = m <<< e;
    end
  endfunction

  wire greater = UNSIGNED_FMT ? (sample_word > peak_word)
                              : (l11_fixed(sample_word) > l11_fixed(peak_word));

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      have_reg <= 1'b0;
      peak_word <= `WORD_ZERO;
    end
    else if (sample_stb && (clear || !have_reg || greater))
    begin
      // First sample after reset or clear seeds the peak
      have_reg <= 1'b1;
      peak_word <= sample_word;
    end
    else if (clear)
    begin
      have_reg <= 1'b0;
      peak_word <= `WORD_ZERO;
    end
  end

endmodule // peak_hold
`default_nettype wire

/* logic/current_calc.v */
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_map.vh"

module current_calc (
  input wire clk,
  input wire sys_rst,
  input wire in_stb,
  input wire in_ch,
  input wire signed [15:0] current_sense_pins_val,
  input wire [15:0] current_gain,
  input wire signed [15:0] current_gain_temp_coeff,
  input wire signed [`MEAS_W-1:0] ext_temp_q8,
  output reg out_stb,
  output reg out_ch,
  output reg signed [31:0] iout_q8
);

  // Raw current from sense voltage and gain
  wire signed [`IGAIN_FRAC+31:0] raw_full = current_sense_pins_val * $signed({1'b0, current_gain});
  wire signed [31:0] i_raw = raw_full[`IGAIN_FRAC+31:`IGAIN_FRAC];
  // Temperature drift of the sense element
  wire signed [`MEAS_W-1:0] dtemp = ext_temp_q8 - `REF_TEMP_Q8;
  wire signed [47:0] s1_full = i_raw * current_gain_temp_coeff;
  wire signed [33:0] s1 = s1_full[`TC_SHIFT1+33:`TC_SHIFT1];
  wire signed [57:0] s2_full = s1 * dtemp;
  wire signed [31:0] corr = s2_full[`TC_SHIFT2+31:`TC_SHIFT2];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_stb <= 1'b0;
      out_ch <= 1'b0;
      iout_q8 <= 32'sh00000000;
    end
    else
    begin
      out_stb <= in_stb;
      if (in_stb)
      begin
        out_ch <= in_ch;
        iout_q8 <= i_raw - corr;
      end
    end
  end

endmodule // current_calc
`default_nettype wire

/* logic/telemetry_readback_bank.v */
// Operation
// - Input voltage read returns linear 11-bit word
// - Input voltage peak held since last clear
// - Output voltage per page, unsigned 16-bit linear
// - Output voltage peak per channel, same format
// - Current from sense, gain, drift, temperature
// - Current peak per channel, linear 11-bit
// - Power is correlated voltage times current
// - Peaks reset only by clear command or sys_rst
// - Telemetry is read-word only, two bytes
// - External temperature per channel, linear 11-bit
// - Internal temperature shared, not paged
// - External temperature peak held since clear
// - Duty cycle per channel, linear 11-bit
// - Input clock frequency per channel, linear 11-bit
// - Clear peaks is send-byte, no data
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_map.vh"

module telemetry_readback_bank (
  input wire clk,
  input wire sys_rst,
  input wire cmd_stb,
  input wire [1:0] cmd_kind,
  input wire [7:0] cmd_code,
  input wire page,
  output reg rsp_valid,
  output reg rsp_ack,
  output reg [15:0] rsp_data,
  input wire vin_stb,
  input wire signed [`MEAS_W-1:0] vin_val,
  input wire vout_stb,
  input wire vout_ch,
  input wire [15:0] vout_val,
  input wire iout_stb,
  input wire iout_ch,
  input wire signed [15:0] current_sense_pins_val,
  input wire ext_temp_stb,
  input wire ext_temp_ch,
  input wire signed [15:0] ext_temp_raw,
  input wire int_temp_stb,
  input wire signed [`MEAS_W-1:0] int_temp_val,
  input wire duty_stb,
  input wire duty_ch,
  input wire signed [`MEAS_W-1:0] duty_val,
  input wire freq_stb,
  input wire freq_ch,
  input wire signed [`MEAS_W-1:0] freq_val,
  input wire [15:0] current_gain,
  input wire signed [15:0] current_gain_temp_coeff,
  input wire [15:0] ext_temp_gain,
  input wire signed [15:0] ext_temp_offset
);

  // Fixed value with Q_FRAC fraction bits to linear 11-bit word
  function [15:0] to_l11;
    input signed [47:0] x;
    reg signed [47:0] v;
    reg signed [5:0] e;
    integer k;
    begin
      v = x;
      e = `L11_BASE_EXP;
      for (k = 0; k < `L11_MAX_SHIFT; k = k + 1)
      begin
        if (v > `L11_MANT_MAX || v < `L11_MANT_MIN)
        begin
          v = v >>> 1;
          e = e + 6'sd1;
        end
      end
      // Beyond the widest exponent the mantissa saturates
      if (v > `L11_MANT_MAX)
      begin
        v = `L11_MANT_MAX;
      end
      else if (v < `L11_MANT_MIN)
      begin
        v = `L11_MANT_MIN;
      end
      to_l11 = {e[4:0], v[10:0]};
    end
  endfunction

  // Signed measurement to linear 11-bit word
  function [15:0] meas_l11;
    input signed [`MEAS_W-1:0] x;
    begin
      meas_l11 = to_l11({{(48-`MEAS_W){x[`MEAS_W-1]}}, x});
    end
  endfunction

  // Peak slot of a paged reading
  function [2:0] slot_of;
    input integer base;
    input pg;
    begin
      slot_of = base[2:0] + {2'b00, pg};
    end
  endfunction

  // Telemetry codes that select a channel by page
  function is_paged;
    input [7:0] code;
    begin
      case (code)
        `CMD_VOUT, `CMD_VOUT_PEAK, `CMD_IOUT, `CMD_IOUT_PEAK, `CMD_POUT,
        `CMD_EXT_TEMP, `CMD_EXT_TEMP_PEAK, `CMD_DUTY, `CMD_FREQ: is_paged = 1'b1;
        default: is_paged = 1'b0;
      endcase
    end
  endfunction

  // Any read-only telemetry code
  function is_telemetry;
    input [7:0] code;
    begin
      case (code)
        `CMD_VIN, `CMD_VIN_PEAK, `CMD_INT_TEMP: is_telemetry = 1'b1;
        default: is_telemetry = is_paged(code);
      endcase
    end
  endfunction

  reg [15:0] vin_word_reg;
  reg [15:0] vout_word_reg [0:1];
  reg [15:0] iout_word_reg [0:1];
  reg [15:0] pout_word_reg [0:1];
  reg [15:0] temp_word_reg [0:1];
  reg signed [`MEAS_W-1:0] temp_q8_reg [0:1];
  reg [15:0] int_temp_word_reg;
  reg [15:0] duty_word_reg [0:1];
  reg [15:0] freq_word_reg [0:1];

  // External temperature with gain and offset applied
  wire signed [`TGAIN_FRAC+`MEAS_W-1:0] temp_full =
    ext_temp_raw * $signed({1'b0, ext_temp_gain});
  wire signed [`MEAS_W-1:0] temp_scaled = temp_full[`TGAIN_FRAC+`MEAS_W-1:`TGAIN_FRAC];
  wire signed [`MEAS_W-1:0] temp_q8_now =
    temp_scaled + {{(`MEAS_W-16){ext_temp_offset[15]}}, ext_temp_offset};

  wire cur_stb;
  wire cur_ch;
  wire signed [31:0] cur_q8;

  current_calc u_current (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_stb(iout_stb),
    .in_ch(iout_ch),
    .current_sense_pins_val(current_sense_pins_val),
    .current_gain(current_gain),
    .current_gain_temp_coeff(current_gain_temp_coeff),
    .ext_temp_q8(temp_q8_reg[iout_ch]),
    .out_stb(cur_stb),
    .out_ch(cur_ch),
    .iout_q8(cur_q8)
  );

  // Power from the latest voltage of the same channel
  wire [15:0] pwr_vout = vout_word_reg[cur_ch];
  wire signed [`VOUT_FRAC+47:0] pwr_full = $signed({1'b0, pwr_vout}) * cur_q8;
  wire signed [47:0] pwr_q8 = pwr_full[`VOUT_FRAC+47:`VOUT_FRAC];
  wire [15:0] cur_word = to_l11({{16{cur_q8[31]}}, cur_q8});
  wire [15:0] temp_word_now = meas_l11(temp_q8_now);
  wire [15:0] vin_word_now = meas_l11(vin_val);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      vin_word_reg <= `WORD_ZERO;
      int_temp_word_reg <= `WORD_ZERO;
    end
    else
    begin
      if (vin_stb)
      begin
        vin_word_reg <= vin_word_now;
      end
      if (int_temp_stb)
      begin
        int_temp_word_reg <= meas_l11(int_temp_val);
      end
    end
  end

  // Per-channel readings, each written only by its own strobe
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : chan
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          vout_word_reg[c] <= `WORD_ZERO;
          iout_word_reg[c] <= `WORD_ZERO;
          pout_word_reg[c] <= `WORD_ZERO;
          temp_word_reg[c] <= `WORD_ZERO;
          temp_q8_reg[c] <= {`MEAS_W{1'b0}};
          duty_word_reg[c] <= `WORD_ZERO;
          freq_word_reg[c] <= `WORD_ZERO;
        end
        else
        begin
          if (vout_stb && vout_ch == c)
          begin
            vout_word_reg[c] <= vout_val;
          end
          if (cur_stb && cur_ch == c)
          begin
            iout_word_reg[c] <= cur_word;
            pout_word_reg[c] <= to_l11(pwr_q8);
          end
          if (ext_temp_stb && ext_temp_ch == c)
          begin
            temp_q8_reg[c] <= temp_q8_now;
            temp_word_reg[c] <= temp_word_now;
          end
          if (duty_stb && duty_ch == c)
          begin
            duty_word_reg[c] <= meas_l11(duty_val);
          end
          if (freq_stb && freq_ch == c)
          begin
            freq_word_reg[c] <= meas_l11(freq_val);
          end
        end
      end
    end
  endgenerate

  // Clear accepted only as a send-byte
  wire clear_peaks = cmd_stb && cmd_kind == `KIND_SEND_BYTE
                     && cmd_code == `CMD_CLEAR_PEAKS;

  // Peak sources, one slot each
  reg [`PEAK_N-1:0] pk_stb;
  reg [15:0] pk_word [0:`PEAK_N-1];
  wire [15:0] pk_out [0:`PEAK_N-1];

  always @*
  begin
    pk_stb = {`PEAK_N{1'b0}};
    pk_stb[`PK_VIN] = vin_stb;
    pk_stb[`PK_VOUT0] = vout_stb && !vout_ch;
    pk_stb[`PK_VOUT0+1] = vout_stb && vout_ch;
    pk_stb[`PK_IOUT0] = cur_stb && !cur_ch;
    pk_stb[`PK_IOUT0+1] = cur_stb && cur_ch;
    pk_stb[`PK_TEMP0] = ext_temp_stb && !ext_temp_ch;
    pk_stb[`PK_TEMP0+1] = ext_temp_stb && ext_temp_ch;
    pk_word[`PK_VIN] = vin_word_now;
    pk_word[`PK_VOUT0] = vout_val;
    pk_word[`PK_VOUT0+1] = vout_val;
    pk_word[`PK_IOUT0] = cur_word;
    pk_word[`PK_IOUT0+1] = cur_word;
    pk_word[`PK_TEMP0] = temp_word_now;
    pk_word[`PK_TEMP0+1] = temp_word_now;
  end

  genvar p;
  generate
    for (p = 0; p < `PEAK_N; p = p + 1)
    begin : peak
      peak_hold #(
        .UNSIGNED_FMT((p == `PK_VOUT0 || p == `PK_VOUT0 + 1) ? 1 : 0)
      ) u_peak (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(clear_peaks),
        .sample_stb(pk_stb[p]),
        .sample_word(pk_word[p]),
        .peak_word(pk_out[p])
      );
    end
  endgenerate

  // Read data selection
  reg [15:0] read_word;

  always @*
  begin
    case (cmd_code)
      `CMD_VIN: read_word = vin_word_reg;
      `CMD_VIN_PEAK: read_word = pk_out[`PK_VIN];
      `CMD_VOUT: read_word = vout_word_reg[page];
      `CMD_VOUT_PEAK: read_word = pk_out[slot_of(`PK_VOUT0, page)];
      `CMD_IOUT: read_word = iout_word_reg[page];
      `CMD_IOUT_PEAK: read_word = pk_out[slot_of(`PK_IOUT0, page)];
      `CMD_POUT: read_word = pout_word_reg[page];
      `CMD_EXT_TEMP: read_word = temp_word_reg[page];
      `CMD_EXT_TEMP_PEAK: read_word = pk_out[slot_of(`PK_TEMP0, page)];
      `CMD_INT_TEMP: read_word = int_temp_word_reg;
      `CMD_DUTY: read_word = duty_word_reg[page];
      `CMD_FREQ: read_word = freq_word_reg[page];
      default: read_word = `WORD_ZERO;
    endcase
  end

  // Response to the command taken this cycle
  reg rsp_ack_next;
  reg [15:0] rsp_data_next;

  always @*
  begin
    rsp_ack_next = rsp_ack;
    rsp_data_next = rsp_data;
    if (cmd_stb)
    begin
      if (cmd_kind == `KIND_READ_WORD && is_telemetry(cmd_code))
      begin
        rsp_ack_next = 1'b1;
        rsp_data_next = read_word;
      end
      else
      begin
        // Writes to telemetry and unknown codes are refused
        rsp_ack_next = clear_peaks;
        rsp_data_next = `WORD_ZERO;
      end
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_data <= `WORD_ZERO;
    end
    else
    begin
      rsp_valid <= cmd_stb;
      rsp_ack <= rsp_ack_next;
      rsp_data <= rsp_data_next;
    end
  end

endmodule // telemetry_readback_bank
`default_nettype wire

/* test/telemetry_readback_bank_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_map.vh"
module bank_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_stb,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_code,
  input wire logic vin_stb,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_data
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic rd = cmd_stb && cmd_kind == `KIND_READ_WORD;
  wire logic sb = cmd_stb && cmd_kind == `KIND_SEND_BYTE;
  wire logic clr = sb && cmd_code == `CMD_CLEAR_PEAKS;
  property p_answer;
    cmd_stb |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("response missing");
  property p_quiet;
    !cmd_stb |=> !rsp_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("response without command");
  property p_write;
    cmd_stb && cmd_kind == `KIND_WRITE |=> !rsp_ack && rsp_data == `WORD_ZERO;
  endproperty
  a_write: assert property (p_write) else $error("write accepted");
  property p_send;
    sb && cmd_code != `CMD_CLEAR_PEAKS |=> !rsp_ack;
  endproperty
  a_send: assert property (p_send) else $error("bad send byte accepted");
  property p_clear;
    clr |=> rsp_ack && rsp_data == `WORD_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not accepted");
  property p_vin;
    rd && cmd_code == `CMD_VIN |=> rsp_ack;
  endproperty
  a_vin: assert property (p_vin) else $error("input voltage read refused");
  property p_hold;
    !rsp_valid |-> $stable(rsp_data) && $stable(rsp_ack);
  endproperty
  a_hold: assert property (p_hold) else $error("response changed while idle");
  property p_peak_clr;
    (clr && !vin_stb) ##1 (rd && cmd_code == `CMD_VIN_PEAK) |=> rsp_data == `WORD_ZERO;
  endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("peak not cleared");
  property p_unknown;
    rd && cmd_code == 8'h00 |=> !rsp_ack && rsp_data == `WORD_ZERO;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code accepted");
  c_clear: cover property (clr);
  c_b2b: cover property (cmd_stb ##1 cmd_stb);
  c_peak: cover property (rd && cmd_code == `CMD_IOUT_PEAK);
endmodule // bank_checker
bind telemetry_readback_bank bank_checker i_chk (.clk(clk), .sys_rst(sys_rst),
  .cmd_stb(cmd_stb), .cmd_kind(cmd_kind), .cmd_code(cmd_code), .vin_stb(vin_stb),
  .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_data(rsp_data));
`default_nettype wire

/* test/pmbus_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
  input wire logic clk,
  output logic cmd_stb,
  output logic [1:0] cmd_kind,
  output logic [7:0] cmd_code,
  output logic page,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_data
);
  initial
  begin
    cmd_stb = 1'b0;
    cmd_kind = 2'h3;
    cmd_code = 8'hFF;
    page = 1'b0;
  end
  // Read-word to telemetry, send-byte without data for clear
  task automatic cmd(input logic [1:0] k, input logic [7:0] c, input logic p,
    output logic ok, output logic [15:0] d, output logic v);
    cmd_stb = 1'b1;
    cmd_kind = k;
    cmd_code = c;
    page = p;
    @(negedge clk);
    v = rsp_valid;
    ok = rsp_ack;
    d = rsp_data;
  endtask
  // Released kind and code lines show inverted garbage, page held
  task automatic idle;
    cmd_stb = 1'b0;
    cmd_kind = ~cmd_kind;
    cmd_code = ~cmd_code;
    @(negedge clk);
  endtask
endmodule // pmbus_host_model
`default_nettype wire

/* test/test_telemetry_readback_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "telemetry_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module test_telemetry_readback_bank;
  logic clk, sys_rst, cmd_stb, page, rsp_valid, rsp_ack, sch;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_code;
  logic [15:0] rsp_data, cg, tc, eg, eo;
  logic [23:0] sval;
  logic [6:0] stb;
  int fails, compares, cyc;
  telemetry_readback_bank i_dut (.clk(clk), .sys_rst(sys_rst), .cmd_stb(cmd_stb),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .page(page), .rsp_valid(rsp_valid),
    .rsp_ack(rsp_ack), .rsp_data(rsp_data), .vin_stb(stb[0]), .vin_val(sval),
    .vout_stb(stb[1]), .vout_ch(sch), .vout_val(sval[15:0]), .iout_stb(stb[2]),
    .iout_ch(sch), .current_sense_pins_val(sval[15:0]), .ext_temp_stb(stb[3]), .ext_temp_ch(sch),
    .ext_temp_raw(sval[15:0]), .int_temp_stb(stb[4]), .int_temp_val(sval),
    .duty_stb(stb[5]), .duty_ch(sch), .duty_val(sval), .freq_stb(stb[6]), .freq_ch(sch),
    .freq_val(sval), .current_gain(cg), .current_gain_temp_coeff(tc), .ext_temp_gain(eg),
    .ext_temp_offset(eo));
  pmbus_host_model i_host (.clk(clk), .cmd_stb(cmd_stb), .cmd_kind(cmd_kind),
    .cmd_code(cmd_code), .page(page), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_data(rsp_data));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fails = fails + 1;
      complete_run;
    end
  end
  task automatic xf(input logic [1:0] k, input logic [7:0] c, input logic p,
    input logic a, input logic [15:0] e);
    logic v, ok;
    logic [15:0] d;
    i_host.cmd(k, c, p, ok, d, v);
    i_host.idle;
    `CHK({v, ok, d}, {1'b1, a, e})
  endtask
  task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e);
    xf(`KIND_READ_WORD, c, p, 1'b1, e);
  endtask
  task automatic smp(input int k, input logic c, input logic [23:0] v);
    stb[k] = 1'b1;
    sch = c;
    sval = v;
    @(negedge clk);
    stb[k] = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_reads;
    smp(0, 0, 24'h000100);
    rd(`CMD_VIN, 0, 16'hC100);
    smp(0, 0, 24'h000080);
    rd(`CMD_VIN, 1, 16'hC080);
    rd(`CMD_VIN_PEAK, 0, 16'hC100);
    smp(1, 1, 24'h001800);
    rd(`CMD_VOUT, 1, 16'h1800);
    rd(`CMD_VOUT, 0, 16'h0000);
    rd(`CMD_VOUT_PEAK, 1, 16'h1800);
    smp(4, 0, 24'h000200);
    rd(`CMD_INT_TEMP, 1, 16'hC200);
    smp(5, 0, 24'h000300);
    rd(`CMD_DUTY, 0, 16'hC300);
    smp(6, 1, 24'h000100);
    rd(`CMD_FREQ, 1, 16'hC100);
    smp(3, 0, 24'h000200);
    rd(`CMD_EXT_TEMP, 0, 16'hC200);
    rd(`CMD_EXT_TEMP_PEAK, 0, 16'hC200);
    eg = 16'h8000;
    eo = 16'h0100;
    smp(3, 1, 24'h000100);
    rd(`CMD_EXT_TEMP, 1, 16'hC300);
    rd(`CMD_EXT_TEMP_PEAK, 1, 16'hC300);
  endtask
  task automatic t_current;
    smp(1, 0, 24'h001000);
    smp(2, 0, 24'h000200);
    rd(`CMD_IOUT, 0, 16'hC200);
    rd(`CMD_POUT, 0, 16'hC200);
    smp(2, 0, 24'h000400);
    rd(`CMD_IOUT, 0, 16'hCA00);
    rd(`CMD_IOUT_PEAK, 0, 16'hCA00);
    rd(`CMD_POUT, 0, 16'hCA00);
    // Drift: 2 A at 2 degC, coefficient 2^-8 per degC
    tc = 16'h1000;
    smp(2, 0, 24'h000200);
    rd(`CMD_IOUT, 0, 16'hC232);
    rd(`CMD_POUT, 0, 16'hC232);
    rd(`CMD_IOUT_PEAK, 0, 16'hCA00);
  endtask
  task automatic t_clear;
    logic v, ok;
    logic [15:0] d;
    i_host.cmd(`KIND_SEND_BYTE, `CMD_CLEAR_PEAKS, 0, ok, d, v);
    `CHK({v, ok, d}, {2'b11, 16'h0000})
    i_host.cmd(`KIND_READ_WORD, `CMD_VIN_PEAK, 0, ok, d, v);
    i_host.idle;
    `CHK(d, 16'h0000)
    rd(`CMD_IOUT_PEAK, 0, 16'h0000);
    rd(`CMD_VOUT_PEAK, 1, 16'h0000);
    rd(`CMD_EXT_TEMP_PEAK, 0, 16'h0000);
    rd(`CMD_VIN, 0, 16'hC080);
    smp(0, 0, 24'h000040);
    rd(`CMD_VIN_PEAK, 0, 16'hC040);
  endtask
  task automatic t_refuse;
    xf(`KIND_WRITE, `CMD_VIN_PEAK, 0, 1'b0, 16'h0000);
    xf(`KIND_READ_WORD, 8'h00, 0, 1'b0, 16'h0000);
    xf(`KIND_SEND_BYTE, `CMD_VIN, 0, 1'b0, 16'h0000);
    xf(2'h3, `CMD_VOUT, 0, 1'b0, 16'h0000);
    rd(`CMD_VIN_PEAK, 0, 16'hC040);
  endtask
  initial
  begin
    fails = 0;
    compares = 0;
    cyc = 0;
    sys_rst = 1'b1;
    stb = 7'h00;
    sch = 1'b0;
    sval = 24'h000000;
    cg = 16'h0100;
    tc = 16'h0000;
    eg = 16'h4000;
    eo = 16'h0000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reads;
    t_current;
    t_clear;
    t_refuse;
    complete_run;
  end
endmodule // test_telemetry_readback_bank
`default_nettype wire
